/* File: common/ltsd_pkg.sv */
/*
 * Shared constants for the literal, table and skip decoder.
 * Assumes a single pclk domain and APB-reached control registers.
 */
package ltsd_pkg;
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CORE   = 8'h04;
  localparam logic [7:0] REG_PROD   = 8'h08;
  localparam logic [7:0] REG_FSR0   = 8'h0c;
  localparam logic [7:0] REG_FSR1   = 8'h10;
  localparam logic [7:0] REG_FSR2   = 8'h14;
  localparam logic [7:0] REG_TBLPTR = 8'h18;
  localparam logic [7:0] REG_TABLAT = 8'h1c;
  // Control register fields
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_EXT_BIT  = 1;
  localparam int CTRL_PSC_BIT  = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // Core status word fields: N OV Z DC C
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam int CORE_STAT_LSB = 8;
  localparam int CORE_BSR_LSB = 16;
  localparam logic [4:0] FLAG_ALL = 5'h1f;
  localparam logic [4:0] FLAG_ZN = 5'h14;
  // Phase counter: four clocks per instruction cycle
  localparam logic [1:0] Q_DECODE = 2'h0;
  localparam logic [1:0] Q_READ = 2'h1;
  localparam logic [1:0] Q_PROC = 2'h2;
  localparam logic [1:0] Q_WRITE = 2'h3;
  // Opcode upper bytes and fields
  localparam logic [7:0] OP_SUBLIT = 8'h08;
  localparam logic [7:0] OP_ORLIT = 8'h09;
  localparam logic [7:0] OP_XORLIT = 8'h0a;
  localparam logic [7:0] OP_ANDLIT = 8'h0b;
  localparam logic [7:0] OP_RETLIT = 8'h0c;
  localparam logic [7:0] OP_MULLIT = 8'h0d;
  localparam logic [7:0] OP_MOVLIT = 8'h0e;
  localparam logic [7:0] OP_ADDLIT = 8'h0f;
  localparam logic [11:0] OP_BANK = 12'h010;
  localparam logic [11:0] OP_TBL = 12'h000;
  localparam logic [9:0] OP_PTR1 = 10'h3b8;
  localparam logic [3:0] OP_PTR2 = 4'hf;
  localparam logic [5:0] OP_INCSZ = 6'h0f;
  localparam logic [5:0] OP_INCSNZ = 6'h12;
  localparam logic [5:0] OP_ORREG = 6'h04;
  localparam logic [5:0] OP_TWOWORD = 6'h3b;
  localparam logic [3:0] OP_MOVFF = 4'hc;
  // Access bank split and upper block
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [7:0] IDX_MAX = 8'h5f;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  // Table pointer adjust modes
  localparam logic [1:0] TBL_NONE = 2'h0;
  localparam logic [1:0] TBL_POSTINC = 2'h1;
  localparam logic [1:0] TBL_POSTDEC = 2'h2;
  localparam logic [1:0] TBL_PREINC = 2'h3;

  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_SUB = 3'b001,
    ALU_AND = 3'b010,
    ALU_OR  = 3'b011,
    ALU_XOR = 3'b100,
    ALU_MOV = 3'b101
  } ltsd_alu_op_t;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'b000,
    ST_NOP2  = 3'b001,
    ST_SKIP  = 3'b010,
    ST_SKIP2 = 3'b011,
    ST_PTR2  = 3'b100
  } ltsd_state_t;
endpackage

/* File: common/ltsd_alu_if.sv */
/*
 * Operand and result bundle between the sequencer and its ALU.
 * Assumes a purely combinational ALU on the alu side.
 */
`timescale 1ns/1ps
`default_nettype none
interface ltsd_alu_if;
  ltsd_pkg::ltsd_alu_op_t op;
  logic [7:0]             a;
  logic [7:0]             b;
  logic [7:0]             res;
  logic [4:0]             flags;
  modport seq (output op, output a, output b, input res, input flags);
  modport alu (input op, input a, input b, output res, output flags);
endinterface
`default_nettype wire

/* File: src/ltsd_alu.sv */
/*
 * 8-bit ALU with carry, digit carry, zero, overflow and negative.
 * Assumes operands are stable for the whole processing phase.
 */
`timescale 1ns/1ps
`default_nettype none
module ltsd_alu (
  // Operand bundle
  ltsd_alu_if.alu bus
);
  logic [7:0] bb;
  logic [8:0] sum;
  logic [4:0] half;
  logic       cin;
  logic [7:0] r;

  always_comb begin
    bb = bus.b;
    cin = 1'b0;
    if (bus.op == ltsd_pkg::ALU_SUB) begin
      bb = ~bus.b;
      cin = 1'b1;
    end
    sum = {1'b0, bus.a} + {1'b0, bb} + {8'h00, cin};
    half = {1'b0, bus.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    case (bus.op)
      ltsd_pkg::ALU_ADD: r = sum[7:0];
      ltsd_pkg::ALU_SUB: r = sum[7:0];
      ltsd_pkg::ALU_AND: r = bus.a & bus.b;
      ltsd_pkg::ALU_OR:  r = bus.a | bus.b;
      ltsd_pkg::ALU_XOR: r = bus.a ^ bus.b;
      default:           r = bus.b;
    endcase
    bus.res = r;
    bus.flags[ltsd_pkg::ST_C] = sum[8];
    bus.flags[ltsd_pkg::ST_DC] = half[4];
    bus.flags[ltsd_pkg::ST_Z] = (r == 8'h00);
    bus.flags[ltsd_pkg::ST_OV] = (bus.a[7] == bb[7]) && (sum[7] != bus.a[7]);
    bus.flags[ltsd_pkg::ST_N] = r[7];
  end
endmodule
`default_nettype wire

/* File: src/ltsd_core.sv */
/*
 * Instruction sequencer for literal, table, increment-skip and OR ops.
 * Assumes fetch holds the current word on instr and advances on
 * fetch_adv; data memory answers dm_rdata in the cycle after dm_addr.
 */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Add literal to working register in one cycle, all five flags updated.
// - AND literal into working register, one cycle, only zero and negative.
// - OR and XOR literal into working register, one cycle, zero and negative.
// - Subtract working register from literal, one cycle, all five flags.
// - Move literal into working register, one cycle, no flag change.
// - Bank load copies 4-bit literal into bank select, no flags.
// - Multiply literal by working register in one cycle, flags unchanged.
// - Return with literal in working register, two cycles, no flags.
// - Two-word pointer load puts 12-bit literal into chosen file pointer.
// - Table read with four pointer modes, two cycles, no flags.
// - Table write with four pointer modes, two cycles, no flags.
// - Port register modified from itself reads pin levels, not latch.
// - Writing timer zero with destination f clears its assigned prescaler.
// - Program counter change or true test costs a second no-op cycle.
// - A stray second instruction word executes as a no-op.
// - Increment, write destination, skip next instruction when result zero.
// - Increment, write destination, skip next instruction when result nonzero.
// - Increment-skip takes one, two, or three cycles by skipped width.
// - Destination bit 0 writes working register, 1 writes register f.
// - Bank bit 0 uses access bank, 1 uses bank select register.
// - Extended set, bank bit 0, operand up to 95 uses indexed offset.
// - OR register with working register, chosen destination, zero and negative.
module ltsd_core #(
  parameter logic [11:0] PORT_ADDR = 12'hf81,
  parameter logic [11:0] TMR_ADDR  = 12'hfd6,
  parameter int          PTR_W     = 21
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Instruction fetch
  input  wire logic [15:0]       instr,
  output logic                   fetch_adv,
  output logic                   ret_pop,
  // Data memory and pins
  input  wire logic [7:0]        dm_rdata,
  input  wire logic [7:0]        pin_in,
  output logic      [11:0]       dm_addr,
  output logic      [7:0]        dm_wdata,
  output logic                   dm_we,
  output logic                   t0_psc_clr,
  // Program memory table port
  input  wire logic [7:0]        tbl_rdata,
  output logic      [PTR_W-1:0]  tbl_ptr,
  output logic      [7:0]        tbl_wdata,
  output logic                   tbl_rd,
  output logic                   tbl_wr
);
  if (PTR_W < 8 || PTR_W > 32) begin : g_bad_ptr_w
    $error("PTR_W out of range");
  end

  ltsd_alu_if alu_bus ();
  ltsd_alu u_alu (.bus(alu_bus));

  ltsd_pkg::ltsd_state_t st_ff;
  logic [1:0]        q_ff;
  logic [15:0]       ir_ff;
  logic [2:0]        ctrl_ff;
  logic [7:0]        working_register_ff;
  logic [4:0]        status_ff;
  logic [3:0]        bsr_ff;
  logic [15:0]       prod_ff;
  logic [11:0]       fsr_ff [3];
  logic [PTR_W-1:0]  tblptr_ff;
  logic [7:0]        tablat_ff;
  logic              tbl_pend_ff;
  logic              tbl_nop_ff;
  logic [11:0]       dm_addr_ff;
  logic [7:0]        dm_wdata_ff;
  logic              dm_we_ff;
  logic              t0_clr_ff;
  logic              fetch_adv_ff;
  logic              ret_pop_ff;
  logic              tbl_rd_ff;
  logic              tbl_wr_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;

  // Decode of the latched word
  logic [7:0] hi8;
  logic [7:0] lit;
  logic       run;
  logic       exec;
  logic       is_lit;
  logic       is_bank;
  logic       is_tbl;
  logic       is_ptr1;
  logic       is_incz;
  logic       is_incnz;
  logic       is_orreg;
  logic       is_regop;
  logic       is_twoword;
  logic       d_bit;
  logic       a_bit;
  logic [7:0] f_val;
  logic       skip_now;
  logic [4:0] flag_mask;
  logic [11:0] ea;

  assign hi8 = ir_ff[15:8];
  assign lit = ir_ff[7:0];
  assign run = ctrl_ff[ltsd_pkg::CTRL_RUN_BIT];
  assign exec = run && (st_ff == ltsd_pkg::ST_EXEC);
  assign is_lit = (hi8 >= ltsd_pkg::OP_SUBLIT) && (hi8 <= ltsd_pkg::OP_ADDLIT);
  assign is_bank = (ir_ff[15:4] == ltsd_pkg::OP_BANK);
  assign is_tbl = (ir_ff[15:4] == ltsd_pkg::OP_TBL) && ir_ff[3];
  assign is_ptr1 = (ir_ff[15:6] == ltsd_pkg::OP_PTR1);
  assign is_incz = (ir_ff[15:10] == ltsd_pkg::OP_INCSZ);
  assign is_incnz = (ir_ff[15:10] == ltsd_pkg::OP_INCSNZ);
  assign is_orreg = (ir_ff[15:10] == ltsd_pkg::OP_ORREG);
  assign is_regop = is_incz || is_incnz || is_orreg;
  assign is_twoword = (ir_ff[15:10] == ltsd_pkg::OP_TWOWORD)
                      || (ir_ff[15:12] == ltsd_pkg::OP_MOVFF);
  assign d_bit = ir_ff[9];
  assign a_bit = ir_ff[8];
  assign f_val = (dm_addr_ff == PORT_ADDR) ? pin_in : dm_rdata;
  assign skip_now = (is_incz && alu_bus.res == 8'h00)
                    || (is_incnz && alu_bus.res != 8'h00);

  // Effective data address from the word at the decode phase
  always_comb begin
    if (instr[8]) begin
      ea = {bsr_ff, instr[7:0]};
    end else if (ctrl_ff[ltsd_pkg::CTRL_EXT_BIT] && instr[7:0] <= ltsd_pkg::IDX_MAX) begin
      ea = fsr_ff[2] + {4'h0, instr[7:0]};
    end else if (instr[7:0] < ltsd_pkg::ACC_SPLIT) begin
      ea = {4'h0, instr[7:0]};
    end else begin
      ea = {ltsd_pkg::ACC_HI_BANK, instr[7:0]};
    end
  end

  // ALU operand steering
  always_comb begin
    alu_bus.op = ltsd_pkg::ALU_MOV;
    alu_bus.a = working_register_ff;
    alu_bus.b = lit;
    flag_mask = 5'h00;
    if (is_regop) begin
      alu_bus.b = f_val;
      if (is_orreg) begin
        alu_bus.op = ltsd_pkg::ALU_OR;
        flag_mask = ltsd_pkg::FLAG_ZN;
      end else begin
        alu_bus.op = ltsd_pkg::ALU_ADD;
        alu_bus.a = 8'h01;
      end
    end else begin
      case (hi8)
        ltsd_pkg::OP_ADDLIT: begin
          alu_bus.op = ltsd_pkg::ALU_ADD;
          flag_mask = ltsd_pkg::FLAG_ALL;
        end
        ltsd_pkg::OP_SUBLIT: begin
          alu_bus.op = ltsd_pkg::ALU_SUB;
          alu_bus.a = lit;
          alu_bus.b = working_register_ff;
          flag_mask = ltsd_pkg::FLAG_ALL;
        end
        ltsd_pkg::OP_ANDLIT: begin
          alu_bus.op = ltsd_pkg::ALU_AND;
          flag_mask = ltsd_pkg::FLAG_ZN;
        end
        ltsd_pkg::OP_ORLIT: begin
          alu_bus.op = ltsd_pkg::ALU_OR;
          flag_mask = ltsd_pkg::FLAG_ZN;
        end
        ltsd_pkg::OP_XORLIT: begin
          alu_bus.op = ltsd_pkg::ALU_XOR;
          flag_mask = ltsd_pkg::FLAG_ZN;
        end
        default: alu_bus.op = ltsd_pkg::ALU_MOV;
      endcase
    end
  end

  // Phase counter and word latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= ltsd_pkg::Q_DECODE;
      ir_ff <= 16'h0000;
      dm_addr_ff <= 12'h000;
    end else if (run) begin
      q_ff <= q_ff + 2'h1;
      if (q_ff == ltsd_pkg::Q_DECODE) begin
        ir_ff <= instr;
        dm_addr_ff <= ea;
      end
    end
  end

  // Sequencer state, advanced at the write phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ltsd_pkg::ST_EXEC;
      tbl_nop_ff <= 1'b0;
    end else if (run && q_ff == ltsd_pkg::Q_WRITE) begin
      tbl_nop_ff <= (st_ff == ltsd_pkg::ST_EXEC) && is_tbl;
      case (st_ff)
        ltsd_pkg::ST_EXEC: begin
          if ((is_lit && hi8 == ltsd_pkg::OP_RETLIT) || is_tbl) begin
            st_ff <= ltsd_pkg::ST_NOP2;
          end else if (is_ptr1) begin
            st_ff <= ltsd_pkg::ST_PTR2;
          end else if (skip_now) begin
            st_ff <= ltsd_pkg::ST_SKIP;
          end else begin
            st_ff <= ltsd_pkg::ST_EXEC;
          end
        end
        ltsd_pkg::ST_SKIP: begin
          st_ff <= is_twoword ? ltsd_pkg::ST_SKIP2 : ltsd_pkg::ST_EXEC;
        end
        default: st_ff <= ltsd_pkg::ST_EXEC;
      endcase
    end
  end

  // Working register, flags, bank select, product
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_register_ff <= 8'h00;
      status_ff <= 5'h00;
      bsr_ff <= 4'h0;
      prod_ff <= 16'h0000;
    end else if (exec && q_ff == ltsd_pkg::Q_PROC) begin
      status_ff <= (status_ff & ~flag_mask) | (alu_bus.flags & flag_mask);
      if (is_bank) begin
        bsr_ff <= lit[3:0];
      end
      if (is_lit && hi8 == ltsd_pkg::OP_MULLIT) begin
        prod_ff <= lit * working_register_ff;
      end else if (is_lit || (is_regop && !d_bit)) begin
        working_register_ff <= alu_bus.res;
      end
    end
  end

  // Data memory write, timer prescaler clear, fetch strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dm_we_ff <= 1'b0;
      dm_wdata_ff <= 8'h00;
      t0_clr_ff <= 1'b0;
      ret_pop_ff <= 1'b0;
      fetch_adv_ff <= 1'b0;
    end else begin
      dm_we_ff <= exec && q_ff == ltsd_pkg::Q_PROC && is_regop && d_bit;
      t0_clr_ff <= exec && q_ff == ltsd_pkg::Q_PROC && is_regop && d_bit
                   && dm_addr_ff == TMR_ADDR && ctrl_ff[ltsd_pkg::CTRL_PSC_BIT];
      ret_pop_ff <= exec && q_ff == ltsd_pkg::Q_PROC && hi8 == ltsd_pkg::OP_RETLIT;
      // Table ops hold fetch in their idle cycle so the next word still runs
      fetch_adv_ff <= run && q_ff == ltsd_pkg::Q_PROC
                      && !(st_ff == ltsd_pkg::ST_NOP2 && tbl_nop_ff);
      if (exec && q_ff == ltsd_pkg::Q_PROC) begin
        dm_wdata_ff <= alu_bus.res;
      end
    end
  end

  logic [1:0] fsr_sel_ff;
  logic [3:0] fsr_hi_ff;

  // File pointers: second word completes the load, stray words do nothing
  for (genvar i = 0; i < 3; i++) begin : g_fsr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fsr_ff[i] <= 12'h000;
      end else if (run && q_ff == ltsd_pkg::Q_PROC && st_ff == ltsd_pkg::ST_PTR2
                   && ir_ff[15:12] == ltsd_pkg::OP_PTR2) begin
        if (fsr_sel_ff == 2'(i)) begin
          fsr_ff[i] <= {fsr_hi_ff, lit};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsr_sel_ff <= 2'h0;
      fsr_hi_ff <= 4'h0;
    end else if (exec && q_ff == ltsd_pkg::Q_PROC && is_ptr1) begin
      fsr_sel_ff <= ir_ff[5:4];
      fsr_hi_ff <= ir_ff[3:0];
    end
  end

  // Table pointer, latch and program memory strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tblptr_ff <= '0;
      tablat_ff <= 8'h00;
      tbl_rd_ff <= 1'b0;
      tbl_wr_ff <= 1'b0;
      tbl_pend_ff <= 1'b0;
    end else begin
      tbl_rd_ff <= 1'b0;
      tbl_wr_ff <= 1'b0;
      if (exec && q_ff == ltsd_pkg::Q_READ && is_tbl) begin
        tbl_rd_ff <= !ir_ff[2];
        tbl_wr_ff <= ir_ff[2];
        tbl_pend_ff <= !ir_ff[2];
        if (ir_ff[1:0] == ltsd_pkg::TBL_PREINC) begin
          tblptr_ff <= tblptr_ff + PTR_W'(1);
        end
      end else if (exec && q_ff == ltsd_pkg::Q_WRITE && is_tbl) begin
        if (ir_ff[1:0] == ltsd_pkg::TBL_POSTINC) begin
          tblptr_ff <= tblptr_ff + PTR_W'(1);
        end else if (ir_ff[1:0] == ltsd_pkg::TBL_POSTDEC) begin
          tblptr_ff <= tblptr_ff - PTR_W'(1);
        end
      end else if (tbl_pend_ff && q_ff == ltsd_pkg::Q_PROC) begin
        tablat_ff <= tbl_rdata;
        tbl_pend_ff <= 1'b0;
      end else if (psel && penable && pwrite && pready_ff) begin
        if (paddr == ltsd_pkg::REG_TBLPTR) tblptr_ff <= pwdata[PTR_W-1:0];
        if (paddr == ltsd_pkg::REG_TABLAT) tablat_ff <= pwdata[7:0];
      end
    end
  end

  // APB slave: one wait state, write lands on the completing edge
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ltsd_pkg::REG_CTRL:   rd_mux[2:0] = ctrl_ff;
      ltsd_pkg::REG_CORE:   rd_mux[19:0] = {bsr_ff, 3'h0, status_ff, working_register_ff};
      ltsd_pkg::REG_PROD:   rd_mux[15:0] = prod_ff;
      ltsd_pkg::REG_FSR0:   rd_mux[11:0] = fsr_ff[0];
      ltsd_pkg::REG_FSR1:   rd_mux[11:0] = fsr_ff[1];
      ltsd_pkg::REG_FSR2:   rd_mux[11:0] = fsr_ff[2];
      ltsd_pkg::REG_TBLPTR: rd_mux[PTR_W-1:0] = tblptr_ff;
      ltsd_pkg::REG_TABLAT: rd_mux[7:0] = tablat_ff;
      default:              rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
      ctrl_ff <= ltsd_pkg::CTRL_RST;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !rd_hit;
      prdata_ff <= (psel && !pwrite) ? rd_mux : 32'h0000_0000;
      if (psel && penable && pwrite && pready_ff && paddr == ltsd_pkg::REG_CTRL) begin
        ctrl_ff <= pwdata[2:0];
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fetch_adv = fetch_adv_ff;
  assign ret_pop = ret_pop_ff;
  assign dm_addr = dm_addr_ff;
  assign dm_wdata = dm_wdata_ff;
  assign dm_we = dm_we_ff;
  assign t0_psc_clr = t0_clr_ff;
  assign tbl_ptr = tblptr_ff;
  assign tbl_wdata = tablat_ff;
  assign tbl_rd = tbl_rd_ff;
  assign tbl_wr = tbl_wr_ff;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_proc;
    exec && q_ff == ltsd_pkg::Q_PROC;
  endsequence

  property p_movlit;
    s_proc and (is_lit && hi8 == ltsd_pkg::OP_MOVLIT)
      |=> working_register_ff == $past(lit) && status_ff == $past(status_ff);
  endproperty
  a_movlit: assert property (p_movlit) else $error("move literal wrong");

  property p_andflags;
    s_proc and (is_lit && hi8 == ltsd_pkg::OP_ANDLIT)
      |=> status_ff[1:0] == $past(status_ff[1:0]) && status_ff[3] == $past(status_ff[3]);
  endproperty
  a_andflags: assert property (p_andflags) else $error("and literal flags");

  property p_bank;
    s_proc and is_bank |=> bsr_ff == $past(lit[3:0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank load wrong");

  property p_skipz;
    s_proc and (is_incz && alu_bus.res == 8'h00) |-> ##2 st_ff == ltsd_pkg::ST_SKIP;
  endproperty
  a_skipz: assert property (p_skipz) else $error("zero skip missed");

  property p_skipnz;
    s_proc and (is_incnz && alu_bus.res == 8'h00) |-> ##2 st_ff == ltsd_pkg::ST_EXEC;
  endproperty
  a_skipnz: assert property (p_skipnz) else $error("nonzero skip wrong");

  property p_ret;
    s_proc and (is_lit && hi8 == ltsd_pkg::OP_RETLIT)
      |=> ret_pop_ff ##1 (st_ff == ltsd_pkg::ST_NOP2 && !ret_pop_ff);
  endproperty
  a_ret: assert property (p_ret) else $error("return sequence wrong");

  property p_dest;
    s_proc and is_regop |=> dm_we_ff == $past(d_bit);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_tmr;
    s_proc and (is_regop && d_bit && dm_addr_ff == TMR_ADDR
                && ctrl_ff[ltsd_pkg::CTRL_PSC_BIT]) |=> t0_clr_ff;
  endproperty
  a_tmr: assert property (p_tmr) else $error("prescaler not cleared");

  property p_banked;
    run && q_ff == ltsd_pkg::Q_DECODE && instr[8] |=> dm_addr_ff == {bsr_ff, ir_ff[7:0]};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_nop2;
    run && st_ff == ltsd_pkg::ST_NOP2 && q_ff == ltsd_pkg::Q_PROC |=> !dm_we_ff;
  endproperty
  a_nop2: assert property (p_nop2) else $error("second cycle not idle");
endmodule
`default_nettype wire

/* File: dv/ltsd_mem_model.sv */
/* Fetch, data memory and table port partner of the decoder.
   Assumes one pclk domain; the bench preloads prog and dm. */
`timescale 1ns/1ps
`default_nettype none
module ltsd_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Fetch
  output logic      [15:0] instr,
  input  wire logic        fetch_adv,
  input  wire logic        ret_pop,
  // Data memory
  input  wire logic [11:0] dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  output logic      [7:0]  dm_rdata,
  // Table port
  input  wire logic [20:0] tbl_ptr,
  input  wire logic [7:0]  tbl_wdata,
  input  wire logic        tbl_wr,
  output logic      [7:0]  tbl_rdata
);
  logic [15:0] prog [64];
  logic [7:0]  dm [64];
  logic [5:0]  pc_ff;
  logic [7:0]  n_ret;
  logic [28:0] tw_last;
  assign instr = prog[pc_ff];
  // Byte depends on pointer so a wrong address shows
  assign tbl_rdata = tbl_ptr[7:0] ^ 8'h5a;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff <= 6'h0;
      n_ret <= 8'h0;
      tw_last <= 29'h0;
    end else begin
      if (fetch_adv) pc_ff <= pc_ff + 6'h1;
      if (ret_pop) n_ret <= n_ret + 8'h1;
      if (tbl_wr) tw_last <= {tbl_ptr, tbl_wdata};
    end
  end
  always_ff @(posedge pclk) begin
    dm_rdata <= dm[dm_addr[5:0]];
    if (dm_we) dm[dm_addr[5:0]] <= dm_wdata;
  end
endmodule
`default_nettype wire

/* File: dv/test_literal_table_skip_decoder.sv */
/* Self-checking bench: runs a short program, then reads state over APB.
   Assumes the mem model as fetch and memory partner. */
`timescale 1ns/1ps
`default_nettype none
module test_literal_table_skip_decoder;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, pin_in, dm_rdata, dm_wdata, tbl_rdata, tbl_wdata;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] instr;
  logic [11:0] dm_addr;
  logic [20:0] tbl_ptr;
  logic        fetch_adv, ret_pop, dm_we, t0_psc_clr, tbl_rd, tbl_wr;
  int          n_fail, checks, n_t0, n_rd;
  localparam logic [15:0] PG [24] = '{16'h0e7f, 16'h0f01, 16'h0bf0,
    16'h0a80, 16'h0935, 16'h0840, 16'h0d02, 16'h0103, 16'hee11, 16'hf034,
    16'h0009, 16'h000f, 16'h3e10, 16'h0e99, 16'h4811, 16'h0e99, 16'h0c77,
    16'h1010, 16'h1281, 16'h3ed6, 16'hee22, 16'h0e55, 16'h4a17, 16'h0d03};
  ltsd_core i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr(instr), .fetch_adv(fetch_adv), .ret_pop(ret_pop), .dm_rdata(dm_rdata),
    .pin_in(pin_in), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
    .t0_psc_clr(t0_psc_clr), .tbl_rdata(tbl_rdata), .tbl_ptr(tbl_ptr),
    .tbl_wdata(tbl_wdata), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr)
  );
  ltsd_mem_model i_mem (
    .pclk(pclk), .presetn(presetn), .instr(instr), .fetch_adv(fetch_adv),
    .ret_pop(ret_pop), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we),
    .dm_rdata(dm_rdata), .tbl_ptr(tbl_ptr), .tbl_wdata(tbl_wdata), .tbl_wr(tbl_wr),
    .tbl_rdata(tbl_rdata)
  );
  // Pulse counters for strobes that leave no trace in registers
  always @(posedge pclk) begin
    if (t0_psc_clr === 1'b1) n_t0++;
    if (tbl_rd === 1'b1) n_rd++;
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pin_in = 8'h88;
    for (int i = 0; i < 64; i++) i_mem.prog[i] = 16'h0103;
    foreach (PG[i]) i_mem.prog[i] = PG[i];
    i_mem.dm[16] = 8'hff;
    i_mem.dm[17] = 8'h05;
    i_mem.dm[1] = 8'h00;
    i_mem.dm[22] = 8'hff;
    i_mem.dm[23] = 8'hff;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(ltsd_pkg::REG_CTRL, 32'h0, "ctrl");
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b1, ltsd_pkg::REG_TBLPTR, 32'h100);
    apb(1'b1, ltsd_pkg::REG_CTRL, 32'h5);
    repeat (160) @(posedge pclk);
    apb(1'b1, ltsd_pkg::REG_CTRL, 32'h0);
    rchk(ltsd_pkg::REG_CORE, 32'h0003_1177, "core");
    rchk(ltsd_pkg::REG_PROD, 32'h165, "prod");
    rchk(ltsd_pkg::REG_FSR1, 32'h134, "fsr1");
    rchk(ltsd_pkg::REG_TABLAT, 32'h5a, "tablat");
    rchk(ltsd_pkg::REG_TBLPTR, 32'h102, "tblptr");
    chk("twr", {3'h0, 21'h102, 8'h5a}, {3'h0, i_mem.tw_last});
    chk("ret", 32'h1, {24'h0, i_mem.n_ret});
    chk("dm16", 32'h0, {24'h0, i_mem.dm[16]});
    chk("dm17", 32'h5, {24'h0, i_mem.dm[17]});
    chk("dm1", 32'hff, {24'h0, i_mem.dm[1]});
    chk("dm22", 32'h0, {24'h0, i_mem.dm[22]});
    chk("dm23", 32'h0, {24'h0, i_mem.dm[23]});
    chk("t0clr", 32'h1, n_t0);
    chk("table_read_op", 32'h1, n_rd);
    end_sim();
  end
endmodule
`default_nettype wire
